/* hdl/pmc_pkg.sv */
package pmc_pkg;

  // ****************************************
  // Offsets
  // ****************************************
  localparam logic [7:0] PMC_OFS_PM = 8'h44;
  localparam logic [7:0] PMC_OFS_MSI_CTL = 8'h4c;
  localparam logic [7:0] PMC_OFS_MSI_LO = 8'h50;
  localparam logic [7:0] PMC_OFS_MSI_HI = 8'h54;

  // ****************************************
  // Field positions and constants
  // ****************************************
  localparam int PMC_BIT_NSR = 3;
  localparam int PMC_BIT_PME_EN = 8;
  localparam int PMC_BIT_PME_ST = 15;
  localparam int PMC_BIT_MSI_EN = 16;
  localparam int PMC_BIT_MSI_64 = 23;
  localparam logic [7:0] PMC_MSI_CAP_ID = 8'h05;
  localparam logic [7:0] PMC_MSI_NEXT = 8'h64;
  localparam logic [1:0] PMC_PS_D0 = 2'h0;
  localparam logic [1:0] PMC_PS_D3 = 2'h3;
  localparam logic PMC_RST_NSR = 1'b1;
  localparam logic [7:0] PMC_RST_DATA = 8'h00;
  localparam logic [31:0] PMC_RST_ADDR = 32'h0000_0000;

  typedef enum logic [2:0] {
    PMC_MW_IDLE = 3'b001,
    PMC_MW_REQ = 3'b010,
    PMC_MW_DONE = 3'b100
  } pmc_mw_e;

  typedef struct packed {
    logic [31:0] addr_hi;
    logic [31:0] addr_lo;
    logic wide;
  } pmc_mw_s;

endpackage : pmc_pkg

/* hdl/pmc_msg_writer.sv */
`timescale 1ns/1ps
module pmc_msg_writer (
  input wire logic mclk_i, // Core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic msi_en_i, // Message enable
  input wire logic [31:0] addr_lo_i, // Low address
  input wire logic [31:0] addr_hi_i, // Upper address
  input wire logic irq_i, // Interrupt condition pulse
  input wire logic mw_ack_i, // Write accepted
  output logic mw_req_o, // Write request
  output pmc_pkg::pmc_mw_s mw_o, // Write target
  output logic intx_o // Legacy interrupt level
);
  pmc_pkg::pmc_mw_e state, next_state;
  pmc_pkg::pmc_mw_s next_mw;
  logic intx, next_intx;

  always_comb begin
    next_state = state;
    next_mw = mw_o;
    next_intx = intx;
    unique case (state)
      pmc_pkg::PMC_MW_IDLE: begin
        if (irq_i && msi_en_i) begin
          next_state = pmc_pkg::PMC_MW_REQ;
          next_mw.addr_lo = {addr_lo_i[31:2], 2'h0};
          next_mw.addr_hi = addr_hi_i;
          next_mw.wide = (addr_hi_i != 32'h0000_0000);
        end
      end
      pmc_pkg::PMC_MW_REQ: begin
        if (mw_ack_i) begin
          next_state = pmc_pkg::PMC_MW_DONE;
        end
      end
      pmc_pkg::PMC_MW_DONE: begin
        next_state = pmc_pkg::PMC_MW_IDLE;
      end
      default: begin
        next_state = pmc_pkg::PMC_MW_IDLE;
      end
    endcase
    // Legacy level only while messages are off
    if (msi_en_i) begin
      next_intx = 1'b0;
    end else if (irq_i) begin
      next_intx = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= pmc_pkg::PMC_MW_IDLE;
      mw_o <= '0;
      intx <= 1'b0;
    end else begin
      state <= next_state;
      mw_o <= next_mw;
      intx <= next_intx;
    end
  end

  assign mw_req_o = (state == pmc_pkg::PMC_MW_REQ);
  assign intx_o = intx;

  a_msi_no_intx: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    msi_en_i |=> !intx_o) else $error("legacy interrupt while messages enabled");
  a_msi_starts: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state == pmc_pkg::PMC_MW_IDLE && irq_i && msi_en_i) |=> mw_req_o)
    else $error("message write not requested");
  a_msi_wide: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(mw_req_o) |-> mw_o.addr_hi == $past(addr_hi_i)
    && mw_o.wide == ($past(addr_hi_i) != 32'h0000_0000))
    else $error("wrong write form");
  c_msi_write: cover property (@(posedge mclk_i) disable iff (!rst_b_i) mw_req_o && mw_ack_i);
endmodule : pmc_msg_writer

/* hdl/pmc_regs.sv */
`timescale 1ns/1ps
module pmc_regs #(
  parameter bit DOWNSTREAM = 1'b1 // Port is a downstream port
) (
  input wire logic mclk_i, // Core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic cfg_wr_i, // Config write strobe
  input wire logic cfg_rd_i, // Config read strobe
  input wire logic [7:0] cfg_addr_i, // Config byte offset
  input wire logic [3:0] cfg_be_i, // Byte enables
  input wire logic [31:0] cfg_wdata_i, // Write data
  output logic [31:0] cfg_rdata_o, // Read data
  output logic cfg_hit_o, // Offset is implemented
  input wire logic preload_i, // Preload strobe from serial bus or autoload
  input wire logic preload_nsr_i, // Preload no-soft-reset value
  input wire logic [7:0] preload_data_i, // Preload data field
  input wire logic irq_i, // Interrupt condition pulse
  input wire logic mw_ack_i, // Message write accepted
  output logic mw_req_o, // Message write request
  output pmc_pkg::pmc_mw_s mw_o, // Message write target
  output logic intx_o, // Legacy interrupt level
  output logic hot_reset_o, // Internal hot reset pulse
  output logic downstream_reset_out_n, // Downstream reset, active low
  output logic pme_en_o, // Power event enable
  output logic [1:0] power_state_o // Current power state
);
  // ****************************************
  // Register state
  // ****************************************
  logic [1:0] pstate, next_pstate;
  logic nsr, next_nsr;
  logic pme_en, next_pme_en;
  logic [3:0] data_sel, next_data_sel;
  logic [7:0] pdata, next_pdata;
  logic msi_en, next_msi_en;
  logic [2:0] mme, next_mme;
  logic [29:0] addr_lo, next_addr_lo;
  logic [31:0] addr_hi, next_addr_hi;
  logic hot_rst, next_hot_rst;
  logic [31:0] rdata, next_rdata;

  function automatic logic [7:0] merge_byte(input logic [31:0] old_v, input int lane);
    merge_byte = cfg_be_i[lane] ? cfg_wdata_i[lane*8 +: 8] : old_v[lane*8 +: 8];
  endfunction : merge_byte

  function automatic logic is_msi(input logic [7:0] a);
    is_msi = DOWNSTREAM && (a == pmc_pkg::PMC_OFS_MSI_CTL || a == pmc_pkg::PMC_OFS_MSI_LO ||
      a == pmc_pkg::PMC_OFS_MSI_HI);
  endfunction : is_msi

  logic [31:0] pm_word, ctl_word, lo_word;
  logic wr_pm, wr_ctl, wr_lo, wr_hi;

  // ****************************************
  // Read words
  // ****************************************
  always_comb begin
    pm_word = '0;
    pm_word[1:0] = pstate;
    pm_word[pmc_pkg::PMC_BIT_NSR] = nsr;
    pm_word[pmc_pkg::PMC_BIT_PME_EN] = pme_en;
    pm_word[12:9] = data_sel;
    pm_word[pmc_pkg::PMC_BIT_PME_ST] = 1'b0;
    pm_word[23:22] = 2'h0;
    pm_word[31:24] = pdata;
    ctl_word = '0;
    ctl_word[7:0] = pmc_pkg::PMC_MSI_CAP_ID;
    ctl_word[15:8] = pmc_pkg::PMC_MSI_NEXT;
    ctl_word[pmc_pkg::PMC_BIT_MSI_EN] = msi_en;
    ctl_word[22:20] = mme;
    ctl_word[pmc_pkg::PMC_BIT_MSI_64] = 1'b1;
    lo_word = {addr_lo, 2'h0};
  end

  assign wr_pm = cfg_wr_i && cfg_addr_i == pmc_pkg::PMC_OFS_PM;
  assign wr_ctl = cfg_wr_i && cfg_addr_i == pmc_pkg::PMC_OFS_MSI_CTL && is_msi(cfg_addr_i);
  assign wr_lo = cfg_wr_i && cfg_addr_i == pmc_pkg::PMC_OFS_MSI_LO && is_msi(cfg_addr_i);
  assign wr_hi = cfg_wr_i && cfg_addr_i == pmc_pkg::PMC_OFS_MSI_HI && is_msi(cfg_addr_i);

  // ****************************************
  // Next values
  // ****************************************
  always_comb begin
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [31:0] lo_new;
    b0 = merge_byte(pm_word, 0);
    b1 = merge_byte(pm_word, 1);
    b2 = merge_byte(ctl_word, 2);
    lo_new = {merge_byte(lo_word, 3), merge_byte(lo_word, 2),
      merge_byte(lo_word, 1), merge_byte(lo_word, 0)};
    next_pstate = pstate;
    next_nsr = nsr;
    next_pme_en = pme_en;
    next_data_sel = data_sel;
    next_pdata = pdata;
    next_msi_en = msi_en;
    next_mme = mme;
    next_addr_lo = addr_lo;
    next_addr_hi = addr_hi;
    next_hot_rst = 1'b0;
    if (preload_i) begin
      next_nsr = preload_nsr_i;
      next_pdata = preload_data_i;
    end
    if (wr_pm) begin
      next_pstate = b0[1:0];
      next_pme_en = b1[0];
      next_data_sel = b1[4:1];
      // D3hot to D0 resets the port unless the no-soft-reset flag is set
      if (cfg_be_i[0] && pstate == pmc_pkg::PMC_PS_D3 && b0[1:0] == pmc_pkg::PMC_PS_D0) begin
        next_hot_rst = 1'b1;
      end
    end
    if (wr_ctl) begin
      next_msi_en = b2[0];
      next_mme = b2[6:4];
    end
    if (wr_lo) begin
      next_addr_lo = lo_new[31:2];
    end
    if (wr_hi) begin
      next_addr_hi = {merge_byte(addr_hi, 3), merge_byte(addr_hi, 2),
        merge_byte(addr_hi, 1), merge_byte(addr_hi, 0)};
    end
    next_rdata = rdata;
    if (cfg_rd_i) begin
      next_rdata = 32'h0000_0000;
      if (cfg_addr_i == pmc_pkg::PMC_OFS_PM) begin
        next_rdata = pm_word;
      end else if (is_msi(cfg_addr_i)) begin
        if (cfg_addr_i == pmc_pkg::PMC_OFS_MSI_CTL) begin
          next_rdata = ctl_word;
        end else if (cfg_addr_i == pmc_pkg::PMC_OFS_MSI_LO) begin
          next_rdata = lo_word;
        end else begin
          next_rdata = addr_hi;
        end
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pstate <= pmc_pkg::PMC_PS_D0;
      nsr <= pmc_pkg::PMC_RST_NSR;
      pme_en <= 1'b0;
      data_sel <= 4'h0;
      pdata <= pmc_pkg::PMC_RST_DATA;
      msi_en <= 1'b0;
      mme <= 3'h0;
      addr_lo <= pmc_pkg::PMC_RST_ADDR[31:2];
      addr_hi <= pmc_pkg::PMC_RST_ADDR;
      hot_rst <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      pstate <= next_pstate;
      nsr <= next_nsr;
      pme_en <= next_pme_en;
      data_sel <= next_data_sel;
      pdata <= next_pdata;
      msi_en <= next_msi_en;
      mme <= next_mme;
      addr_lo <= next_addr_lo;
      addr_hi <= next_addr_hi;
      hot_rst <= next_hot_rst;
      rdata <= next_rdata;
    end
  end

  assign cfg_rdata_o = rdata;
  assign cfg_hit_o = (cfg_addr_i == pmc_pkg::PMC_OFS_PM) || is_msi(cfg_addr_i);
  // Internal reset only when no-soft-reset is clear
  assign hot_reset_o = hot_rst && !nsr;
  assign downstream_reset_out_n = 1'b1;
  assign pme_en_o = pme_en;
  assign power_state_o = pstate;

  pmc_msg_writer u_writer (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .msi_en_i(msi_en && DOWNSTREAM),
    .addr_lo_i({addr_lo, 2'h0}),
    .addr_hi_i(addr_hi),
    .irq_i(irq_i),
    .mw_ack_i(mw_ack_i),
    .mw_req_o(mw_req_o),
    .mw_o(mw_o),
    .intx_o(intx_o)
  );

  // ****************************************
  // Checks
  // ****************************************
  a_d3_d0_reset: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_pm && cfg_be_i[0] && pstate == pmc_pkg::PMC_PS_D3 && cfg_wdata_i[1:0] == 2'h0 && !nsr)
    |=> hot_reset_o) else $error("no hot reset on D3hot to D0");
  a_no_dn_reset: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    hot_reset_o |-> downstream_reset_out_n) else $error("downstream reset driven");
  a_nsr_blocks: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    nsr |-> !hot_reset_o) else $error("reset despite no-soft-reset");
  a_pstate_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_pm && cfg_be_i[0]) |=> power_state_o == $past(cfg_wdata_i[1:0]))
    else $error("power state not stored");
  a_pm_fixed: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (cfg_rd_i && cfg_addr_i == pmc_pkg::PMC_OFS_PM) |=> cfg_rdata_o[15] == 1'b0
    && cfg_rdata_o[23:22] == 2'h0) else $error("fixed power bits not zero");
  a_pme_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !wr_pm |=> pme_en_o == $past(pme_en_o)) else $error("event enable changed");
  a_msi_header: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (cfg_rd_i && cfg_addr_i == pmc_pkg::PMC_OFS_MSI_CTL && DOWNSTREAM) |=>
    cfg_rdata_o[15:0] == 16'h6405 && cfg_rdata_o[23]) else $error("bad capability header");
  a_data_ro: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !preload_i |=> pdata == $past(pdata)) else $error("data field changed");
  a_addr_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (cfg_rd_i && cfg_addr_i == pmc_pkg::PMC_OFS_MSI_LO && DOWNSTREAM) |=>
    cfg_rdata_o[1:0] == 2'h0) else $error("address low bits set");
  a_upstream_msi: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!DOWNSTREAM && cfg_rd_i && cfg_addr_i != pmc_pkg::PMC_OFS_PM) |=> cfg_rdata_o == 32'h0)
    else $error("capability on upstream port");
  c_d3_to_d0: cover property (@(posedge mclk_i) disable iff (!rst_b_i) hot_reset_o);
  c_msi_on: cover property (@(posedge mclk_i) disable iff (!rst_b_i) $rose(msi_en));
  c_preload: cover property (@(posedge mclk_i) disable iff (!rst_b_i) preload_i);
endmodule : pmc_regs

/* bench/pmc_ack_model.sv */
`timescale 1ns/1ps
// ****************************************
// Fabric side that accepts message writes
// ****************************************
module pmc_ack_model (
  input wire logic mclk_i, // Core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic [3:0] delay_i, // Cycles before accept
  input wire logic mw_req_i, // Write request
  output logic mw_ack_o // Write accepted, one cycle
);
  logic [3:0] cnt;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 4'h0;
      mw_ack_o <= 1'b0;
    end else if (mw_req_i && !mw_ack_o && cnt >= delay_i) begin
      cnt <= 4'h0;
      mw_ack_o <= 1'b1;
    end else begin
      cnt <= (mw_req_i && !mw_ack_o) ? cnt + 4'h1 : 4'h0;
      mw_ack_o <= 1'b0;
    end
  end
endmodule : pmc_ack_model

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic mclk_i = 0, rst_b_i = 0, cfg_wr_i = 0, cfg_rd_i = 0, preload_i = 0, preload_nsr_i = 1;
  logic irq_i = 0, mw_ack_i, mw_req_o, intx_o, hot_reset_o, downstream_reset_out_n, pme_en_o;
  logic cfg_hit_o;
  logic [7:0] cfg_addr_i = 8'h00, preload_data_i = 8'h00, pdat;
  logic [3:0] cfg_be_i = 4'h0, ack_dly = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o, lo, hi, rd;
  logic [1:0] power_state_o;
  pmc_pkg::pmc_mw_s mw_o;
  int err_count = 0, compares = 0, hr_cnt = 0, dn_cnt = 0;

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  pmc_regs i_pmc_regs (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_hit_o(cfg_hit_o),
    .preload_i(preload_i), .preload_nsr_i(preload_nsr_i), .preload_data_i(preload_data_i),
    .irq_i(irq_i), .mw_ack_i(mw_ack_i), .mw_req_o(mw_req_o), .mw_o(mw_o), .intx_o(intx_o),
    .hot_reset_o(hot_reset_o), .downstream_reset_out_n(downstream_reset_out_n),
    .pme_en_o(pme_en_o), .power_state_o(power_state_o));
  pmc_ack_model i_pmc_ack_model (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .delay_i(ack_dly),
    .mw_req_i(mw_req_o), .mw_ack_o(mw_ack_i));

  always @(posedge mclk_i) begin
    if (hot_reset_o === 1'b1) hr_cnt++;
    if (downstream_reset_out_n !== 1'b1) dn_cnt++;
  end

  // ****************************************
  // Expectations and bus tasks
  // ****************************************
  function automatic logic [31:0] exp_pm(logic [1:0] ps, logic pme, logic [3:0] sel,
                                         logic nsr, logic [7:0] dat);
    return {dat, 8'h00, 3'b000, sel, pme, 4'h0, nsr, 1'b0, ps};
  endfunction : exp_pm
  function automatic logic [31:0] exp_ctl(logic en, logic [2:0] mme);
    return {8'h00, 1'b1, mme, 3'b000, en, 8'h64, 8'h05};
  endfunction : exp_ctl
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge mclk_i);
    cfg_wr_i = 1; cfg_addr_i = a; cfg_be_i = be; cfg_wdata_i = d;
    @(negedge mclk_i);
    cfg_wr_i = 0;
  endtask : wr
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(negedge mclk_i);
    cfg_rd_i = 1; cfg_addr_i = a;
    @(negedge mclk_i);
    cfg_rd_i = 0;
    @(negedge mclk_i);
    check(what, exp, cfg_rdata_o);
  endtask : rdc
  task automatic fire(input logic en, input logic [31:0] lo_e, input logic [31:0] hi_e);
    int n;
    n = 0;
    @(negedge mclk_i) irq_i = 1;
    @(negedge mclk_i) irq_i = 0;
    while (en && mw_req_o !== 1'b1 && n < 20) begin @(negedge mclk_i); n++; end
    check("mw_req", {31'h0, en}, {31'h0, mw_req_o});
    if (en) begin
      check("mw_addr_lo", lo_e, mw_o.addr_lo);
      check("mw_addr_hi", hi_e, mw_o.addr_hi);
      check("mw_wide", {31'h0, hi_e != 0}, {31'h0, mw_o.wide});
    end
    while (mw_req_o !== 1'b0 && n < 60) begin @(negedge mclk_i); n++; end
    check("mw_req_drop", 32'h0, {31'h0, mw_req_o});
    check("intx", {31'h0, !en}, {31'h0, intx_o});
  endtask : fire
  task conclude;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial begin
    #(40 * 5000);
    err_count++;
    conclude();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h84dd));
    repeat (10) @(negedge mclk_i);
    rst_b_i = 1;
    rdc("pm_reset", 8'h44, exp_pm(2'h0, 1'b0, 4'h0, 1'b1, 8'h00));
    rdc("ctl_reset", 8'h4c, exp_ctl(1'b0, 3'h0));
    rdc("lo_reset", 8'h50, 32'h0);
    rdc("hi_reset", 8'h54, 32'h0);
    check("hit_cap", 32'h1, {31'h0, cfg_hit_o});
    rdc("unmapped", 8'h58, 32'h0);
    check("hit_unmapped", 32'h0, {31'h0, cfg_hit_o});
    wr(8'h44, 4'hf, 32'hffff_ffff);
    rdc("pm_ones", 8'h44, exp_pm(2'h3, 1'b1, 4'hf, 1'b1, 8'h00));
    check("ps_port", 32'h3, {30'h0, power_state_o});
    check("pme_port", 32'h1, {31'h0, pme_en_o});
    wr(8'h44, 4'h1, 32'h0);
    repeat (3) @(negedge mclk_i);
    check("hot_reset_nsr1", 32'h0, hr_cnt);
    pdat = 8'($urandom);
    @(negedge mclk_i);
    preload_i = 1; preload_nsr_i = 0; preload_data_i = pdat;
    @(negedge mclk_i) preload_i = 0;
    foreach (pdat[k]) begin
      wr(8'h44, 4'h1, {30'h0, k[1:0]});
      check("ps_walk", {30'h0, k[1:0]}, {30'h0, power_state_o});
    end
    wr(8'h44, 4'h1, 32'h3);
    wr(8'h44, 4'h1, 32'h0);
    repeat (3) @(negedge mclk_i);
    check("hot_reset_nsr0", 32'h1, hr_cnt);
    check("dn_reset", 32'h0, dn_cnt);
    rdc("pm_preload", 8'h44, exp_pm(2'h0, 1'b1, 4'hf, 1'b0, pdat));
    wr(8'h4c, 4'hf, 32'h0);
    fire(1'b0, 32'h0, 32'h0);
    wr(8'h4c, 4'hf, 32'hffff_ffff);
    rdc("ctl_ones", 8'h4c, exp_ctl(1'b1, 3'h7));
    check("intx_off", 32'h0, {31'h0, intx_o});
    for (int i = 0; i < 6; i++) begin
      lo = $urandom;
      hi = (i % 2) ? $urandom : 32'h0;
      ack_dly = $urandom_range(0, 9);
      wr(8'h50, 4'hf, lo);
      wr(8'h54, 4'hf, hi);
      rdc("addr_lo", 8'h50, lo & 32'hffff_fffc);
      rdc("addr_hi", 8'h54, hi);
      fire(1'b1, lo & 32'hffff_fffc, hi);
    end
    wr(8'h54, 4'b0101, 32'ha5a5_a5a5);
    rdc("hi_bytes", 8'h54, {hi[31:24], 8'ha5, hi[15:8], 8'ha5});
    conclude();
  end
endmodule : testbench
